// >>> pmt8_pkg.sv
// Constants shared by the 8-bit period match timer files
`default_nettype none
package pmt8_pkg;
  // Bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  // Register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_PERIOD = 5'h08;
  localparam logic [4:0] OFS_FLAG = 5'h0c;
  localparam logic [4:0] OFS_IRQ_EN = 5'h10;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control field positions
  localparam int CTL_W = 7;
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_PRE_MSB = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_POST_MSB = 6;
  localparam int FLAG_BIT = 1;
  // Input divider selections and terminal counts
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;
  // Instruction clock is one quarter of the core clock
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [CTL_W-1:0] CONTROL_RST = 7'h00;
endpackage
`default_nettype wire

// >>> pmt8_axil_slave.sv
// AXI4-Lite slave front end for the period match timer
`timescale 1ns/10ps
`default_nettype none
module pmt8_axil_slave
  import pmt8_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [pmt8_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [pmt8_pkg::DATA_W-1:0] wdata_i,
  input wire logic [pmt8_pkg::STRB_W-1:0] wstrb_i,
  // Write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // Read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [pmt8_pkg::ADDR_W-1:0] araddr_i,
  // Read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [pmt8_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  // Register side
  output logic wr_fire_o,
  output logic [pmt8_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [pmt8_pkg::DATA_W-1:0] wr_data_o,
  output logic [pmt8_pkg::STRB_W-1:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic rd_fire_o,
  output logic [pmt8_pkg::ADDR_W-1:0] rd_addr_o,
  input wire logic [pmt8_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_ok_i
);
  logic aw_full_reg;
  logic w_full_reg;
  wire aw_take = awvalid_i & awready_o;
  wire w_take = wvalid_i & wready_o;
  wire b_done = bvalid_o & bready_i;
  wire r_done = rvalid_o & rready_i;
  assign wr_fire_o = aw_full_reg & w_full_reg & ~bvalid_o;
  assign rd_fire_o = arvalid_i & arready_o;
  assign rd_addr_o = araddr_i;

  // Write channels, either order
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        awready_o <= 1'b0;
        aw_full_reg <= 1'b1;
        wr_addr_o <= awaddr_i;
      end
      if (w_take)
      begin
        wready_o <= 1'b0;
        w_full_reg <= 1'b1;
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
      end
      if (wr_fire_o)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done)
      begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end
    else if (rd_fire_o)
    begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= rd_data_i;
      rresp_o <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_done)
    begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pmt8_timer.sv
// Top of the 8-bit period match timer with its register file
// How it works
// - The timer value counts up from zero once per divided tick of the quarter-rate clock.
// - Control bits one and zero pick the input division: 00 by one, 01 by four, 1x by sixteen.
// - Timer value and period value are compared continuously and a match signal shows equality.
// - A match returns the timer value to zero on the next tick, giving period plus one ticks.
// - Matches feed a four-bit output divider whose ratio is control bits six to three plus one.
// - When the output divider completes its count the latched match flag in flag bit one is set.
// - The match flag raises the interrupt only while enable bit one is set.
// - Any reset clears the timer value and loads the period value with all ones.
// - Both divider counters clear on a timer value write, a control write and any reset.
// - A control write leaves the timer value as it was.
// - Control bit two runs the timer when set and stops it when clear.
// - Timer value and period value are readable and writable at any time.
// - Control bit seven reads as zero and ignores writes.
// - The undivided match pulse is brought out as a time base for other units.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pmt8_timer
  import pmt8_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [pmt8_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [pmt8_pkg::DATA_W-1:0] wdata_i,
  input wire logic [pmt8_pkg::STRB_W-1:0] wstrb_i,
  // Write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // Read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [pmt8_pkg::ADDR_W-1:0] araddr_i,
  // Read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [pmt8_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  // Timer outputs
  output logic time_base_o,
  output logic irq_o
);
  import pmt8_pkg::*;

  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic rd_fire;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_ok;
  logic rd_ok;

  logic [1:0] instr_cnt_reg;
  logic [CTL_W-1:0] control_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_cnt_next;
  logic [3:0] post_cnt_reg;
  logic [3:0] post_cnt_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] period_reg;
  logic flag_reg;
  logic flag_next;
  logic irq_en_reg;
  logic time_base_reg;
  logic irq_reg;

  // Register bus slave
  pmt8_axil_slave u_bus (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .bresp_o(bresp_o),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .araddr_i(araddr_i),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .wr_fire_o(wr_fire),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_fire_o(rd_fire),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // Address decode
  wire [ADDR_W-1:0] wr_word = {wr_addr[ADDR_W-1:2], 2'h0};
  wire [ADDR_W-1:0] rd_word = {rd_addr[ADDR_W-1:2], 2'h0};
  wire wr_lane = wr_fire & wr_strb[0];
  wire ctl_wr = wr_lane & (wr_word == OFS_CONTROL);
  wire cnt_wr = wr_lane & (wr_word == OFS_COUNT);
  wire per_wr = wr_lane & (wr_word == OFS_PERIOD);
  wire flg_wr = wr_lane & (wr_word == OFS_FLAG);
  wire ien_wr = wr_lane & (wr_word == OFS_IRQ_EN);
  wire rd_flag = rd_fire & (rd_word == OFS_FLAG);
  assign wr_ok = (wr_word == OFS_CONTROL) | (wr_word == OFS_COUNT) | (wr_word == OFS_PERIOD)
    | (wr_word == OFS_FLAG) | (wr_word == OFS_IRQ_EN);
  assign rd_ok = (rd_word == OFS_CONTROL) | (rd_word == OFS_COUNT) | (rd_word == OFS_PERIOD)
    | (rd_word == OFS_FLAG) | (rd_word == OFS_IRQ_EN);

  // Control fields
  wire [1:0] pre_sel = control_reg[CTL_PRE_MSB:CTL_PRE_LSB];
  wire run = control_reg[CTL_RUN_BIT];
  wire [3:0] post_sel = control_reg[CTL_POST_MSB:CTL_POST_LSB];

  // Divider clearing events
  wire div_clr = ctl_wr | cnt_wr;

  // Quarter-rate instruction tick
  wire instr_tick = (instr_cnt_reg == INSTR_LAST);

  // Input divider
  wire [3:0] pre_last = (pre_sel == PRE_SEL_1) ? PRE_LAST_1 :
    (pre_sel == PRE_SEL_4) ? PRE_LAST_4 : PRE_LAST_16;
  wire pre_step = run & instr_tick & ~div_clr;
  wire pre_tick = pre_step & (pre_cnt_reg == pre_last);

  // Comparator and output divider
  wire match_hit = (count_reg == period_reg);
  wire match_evt = pre_tick & match_hit;
  wire post_done = match_evt & (post_cnt_reg == post_sel);

  assign pre_cnt_next = div_clr ? 4'h0 :
    pre_tick ? 4'h0 :
    pre_step ? 4'(pre_cnt_reg + 4'h1) : pre_cnt_reg;

  assign count_next = cnt_wr ? wr_data[7:0] :
    match_evt ? COUNT_RST :
    pre_tick ? 8'(count_reg + 8'h01) : count_reg;

  assign post_cnt_next = div_clr ? 4'h0 :
    post_done ? 4'h0 :
    match_evt ? 4'(post_cnt_reg + 4'h1) : post_cnt_reg;

  // Set wins over any clear
  assign flag_next = post_done ? 1'b1 :
    flg_wr ? wr_data[FLAG_BIT] :
    rd_flag ? 1'b0 : flag_reg;

  // Read data selection
  wire [7:0] flag_byte = {6'h00, flag_reg, 1'b0};
  wire [7:0] ien_byte = {6'h00, irq_en_reg, 1'b0};
  wire [7:0] rd_byte = (rd_word == OFS_CONTROL) ? {1'b0, control_reg} :
    (rd_word == OFS_COUNT) ? count_reg :
    (rd_word == OFS_PERIOD) ? period_reg :
    (rd_word == OFS_FLAG) ? flag_byte :
    (rd_word == OFS_IRQ_EN) ? ien_byte : 8'h00;
  assign rd_data = {{(DATA_W-8){1'b0}}, rd_byte};

  // Instruction clock divider
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      instr_cnt_reg <= 2'h0;
    else
      instr_cnt_reg <= 2'(instr_cnt_reg + 2'h1);
  end

  // Counters
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count_reg <= COUNT_RST;
      pre_cnt_reg <= 4'h0;
      post_cnt_reg <= 4'h0;
    end
    else
    begin
      count_reg <= count_next;
      pre_cnt_reg <= pre_cnt_next;
      post_cnt_reg <= post_cnt_next;
    end
  end

  // Software registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      control_reg <= CONTROL_RST;
      period_reg <= PERIOD_RST;
      irq_en_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      if (ctl_wr)
        control_reg <= wr_data[CTL_W-1:0];
      if (per_wr)
        period_reg <= wr_data[7:0];
      if (ien_wr)
        irq_en_reg <= wr_data[FLAG_BIT];
      flag_reg <= flag_next;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      time_base_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      time_base_reg <= match_evt;
      irq_reg <= flag_next & irq_en_reg;
    end
  end
  assign time_base_o = time_base_reg;
  assign irq_o = irq_reg;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_count_step;
    pre_tick && !match_hit && !cnt_wr |=> count_reg == 8'($past(count_reg) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("timer value did not advance by one");

  property p_pre_four;
    (pre_sel == PRE_SEL_4) && pre_tick |-> pre_cnt_reg == PRE_LAST_4;
  endproperty
  a_pre_four: assert property (p_pre_four)
    else $error("input divider by four ticked early");

  property p_pre_one;
    (pre_sel == PRE_SEL_1) && run && instr_tick && !div_clr |-> pre_tick;
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("undivided input missed a tick");

  property p_match_out;
    pre_tick && match_hit |=> time_base_o;
  endproperty
  a_match_out: assert property (p_match_out)
    else $error("match pulse missing");

  property p_wrap;
    match_evt && !cnt_wr |=> count_reg == COUNT_RST;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("timer value not zero after match");

  property p_post_done;
    post_done |-> post_cnt_reg == post_sel;
  endproperty
  a_post_done: assert property (p_post_done)
    else $error("output divider finished at wrong count");

  property p_flag_set;
    post_done |=> flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("match flag not set");

  property p_irq;
    flag_reg && irq_en_reg && !rd_flag && !flg_wr |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  property p_irq_gate;
    !irq_en_reg && !$past(irq_en_reg) |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");

  property p_reset;
    disable iff (1'b0) srst_i |=> count_reg == COUNT_RST && period_reg == PERIOD_RST;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset values wrong");

  property p_div_clear;
    div_clr |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0;
  endproperty
  a_div_clear: assert property (p_div_clear)
    else $error("dividers not cleared on write");

  property p_ctl_keeps;
    ctl_wr && !cnt_wr |=> $stable(count_reg);
  endproperty
  a_ctl_keeps: assert property (p_ctl_keeps)
    else $error("control write moved timer value");

  property p_stopped;
    !run && !cnt_wr |=> $stable(count_reg) && !time_base_o;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped timer advanced");

  property p_cnt_write;
    cnt_wr |=> count_reg == $past(wr_data[7:0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("timer value write lost");

  property p_bit7;
    rd_fire && (rd_word == OFS_CONTROL) |=> rdata_o[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7)
    else $error("control bit seven not zero");

  property p_no_pre_stop;
    !run && !ctl_wr |=> !match_evt;
  endproperty
  a_no_pre_stop: assert property (p_no_pre_stop)
    else $error("match while stopped");

  property p_flag_hold;
    flag_reg && !rd_flag && !flg_wr |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("match flag dropped without clear");

  c_match: cover property (match_evt);
  c_flag: cover property (post_done && post_sel == 4'h3);
  c_irq: cover property (irq_o);
  c_read_clear: cover property (rd_flag && flag_reg);
endmodule
`default_nettype wire

// >>> pmt8_timer_tb_top.sv
// Self-checking testbench for the 8-bit period match timer
`timescale 1ns/10ps
`default_nettype none
module pmt8_timer_tb_top;
  import pmt8_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic awvalid_i = 1'b0;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  logic [ADDR_W-1:0] awaddr_i = '0;
  logic [ADDR_W-1:0] araddr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [STRB_W-1:0] wstrb_i = '0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, time_base_o, irq_o;
  logic [1:0] bresp_o, rresp_o;
  logic [DATA_W-1:0] rdata_o;
  logic [1:0] last_bresp;
  int n_errors = 0;
  int check_count = 0;

  pmt8_timer u_dut (
    .clk_i(clk_i), .srst_i(srst_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .time_base_o(time_base_o), .irq_o(irq_o)
  );

  always #2.5 clk_i = ~clk_i;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [7:0] d);
    int g;
    g = 0;
    @(posedge clk_i);
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    awaddr_i <= a;
    wdata_i <= {24'h00_0000, d};
    wstrb_i <= 4'hf;
    bready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      g++;
      if (awvalid_i && awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (!(bready_i && bvalid_o === 1'b1) && g < 50);
    last_bresp = bresp_o;
    bready_i <= 1'b0;
    awvalid_i <= 1'b0;
    wvalid_i <= 1'b0;
    if (g >= 50)
    begin
      check("write_timeout", 0, 1);
      tally_and_finish();
    end
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int g;
    g = 0;
    @(posedge clk_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    rready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      g++;
      if (arvalid_i && arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (!(rready_i && rvalid_o === 1'b1) && g < 50);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
    arvalid_i <= 1'b0;
    if (g >= 50)
    begin
      check("read_timeout", 0, 1);
      tally_and_finish();
    end
  endtask

  task automatic read_check(input string name, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(name, d, exp);
    check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic wait_pulse(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk_i);
      cyc++;
    end while (time_base_o !== 1'b1 && cyc < 5000);
    if (cyc >= 5000)
    begin
      check("pulse_wait", 0, 1);
      tally_and_finish();
    end
  endtask

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  // Watchdog
  initial
  begin
    #150us;
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    tally_and_finish();
  end

  initial
  begin
    int cyc, n, k, np;
    int pre_tab[4];
    int post_tab[3];
    logic [31:0] d;
    logic [1:0] r;
    pre_tab = '{1, 4, 16, 16};
    post_tab = '{15, 3, 0};
    do_reset();
    // Reset values
    read_check("control_rst", OFS_CONTROL, 32'h0000_0000);
    read_check("count_rst", OFS_COUNT, 32'h0000_0000);
    read_check("period_rst", OFS_PERIOD, 32'h0000_00ff);
    read_check("flag_rst", OFS_FLAG, 32'h0000_0000);
    check("irq_rst", {31'h0, irq_o}, 32'h0000_0000);
    $display("test reset_values done");
    // Register access, unused bit, unmapped place
    axi_write(OFS_CONTROL, 8'hff);
    read_check("control_bit7", OFS_CONTROL, 32'h0000_007f);
    axi_write(OFS_CONTROL, 8'h00);
    axi_write(OFS_PERIOD, 8'ha5);
    read_check("period_rw", OFS_PERIOD, 32'h0000_00a5);
    axi_write(OFS_COUNT, 8'h55);
    axi_write(OFS_CONTROL, 8'h78);
    read_check("count_after_ctl", OFS_COUNT, 32'h0000_0055);
    read_check("control_rw", OFS_CONTROL, 32'h0000_0078);
    axi_read(5'h14, d, r);
    check("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(5'h18, 8'h01);
    check("unmapped_bresp", {30'h0, last_bresp}, {30'h0, RESP_SLVERR});
    $display("test register_access done");
    // Match period for every input divider code
    axi_write(OFS_PERIOD, 8'h03);
    axi_write(OFS_COUNT, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      axi_write(OFS_CONTROL, 8'h04 | 8'(i));
      wait_pulse(cyc);
      wait_pulse(cyc);
      check("match_gap", 32'(cyc), 32'(4 * pre_tab[i] * 4));
    end
    $display("test input_divider done");
    // Output divider, latched flag and interrupt
    axi_write(OFS_CONTROL, 8'h00);
    read_check("flag_after_match", OFS_FLAG, 32'h0000_0002);
    axi_write(OFS_PERIOD, 8'h07);
    axi_write(OFS_IRQ_EN, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      axi_write(OFS_CONTROL, 8'h00);
      axi_write(OFS_COUNT, 8'h00);
      axi_write(OFS_CONTROL, 8'h04 | 8'(post_tab[i] << 3));
      n = 0;
      k = 0;
      cyc = 0;
      while (k < 3 && cyc < 2000)
      begin
        @(posedge clk_i);
        cyc++;
        if (time_base_o === 1'b1) n++;
        if (irq_o === 1'b1) k++;
      end
      check("matches_to_flag", 32'(n), 32'(post_tab[i] + 1));
      wait_pulse(cyc);
      wait_pulse(cyc);
      check("irq_held", {31'h0, irq_o}, 32'h0000_0001);
      axi_write(OFS_CONTROL, 8'h00);
      read_check("flag_set", OFS_FLAG, 32'h0000_0002);
      repeat (3) @(posedge clk_i);
      check("irq_cleared", {31'h0, irq_o}, 32'h0000_0000);
    end
    $display("test output_divider done");
    // Masked interrupt
    axi_write(OFS_IRQ_EN, 8'h00);
    axi_write(OFS_CONTROL, 8'h04);
    wait_pulse(cyc);
    wait_pulse(cyc);
    check("irq_masked", {31'h0, irq_o}, 32'h0000_0000);
    axi_write(OFS_CONTROL, 8'h00);
    read_check("flag_masked", OFS_FLAG, 32'h0000_0002);
    $display("test irq_mask done");
    // Stopped timer holds still
    axi_write(OFS_COUNT, 8'h05);
    np = 0;
    repeat (200)
    begin
      @(posedge clk_i);
      if (time_base_o === 1'b1) np++;
    end
    check("stopped_pulses", 32'(np), 32'h0000_0000);
    read_check("stopped_count", OFS_COUNT, 32'h0000_0005);
    $display("test stopped done");
    // Reset while running
    axi_write(OFS_CONTROL, 8'h04);
    repeat (40) @(posedge clk_i);
    do_reset();
    read_check("count_rerst", OFS_COUNT, 32'h0000_0000);
    read_check("period_rerst", OFS_PERIOD, 32'h0000_00ff);
    read_check("control_rerst", OFS_CONTROL, 32'h0000_0000);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
